// ===== logic/hpp_host_port.sv
`timescale 1ns/1ps
module hpp_host_port
	import hpp_pkg::*;
(
	input  wire logic       mclk,              // System clock
	input  wire logic       rst_n,             // Synchronous reset, active low
	input  wire logic       bus_mode_sel_hi,   // Strap: narrow bus when high
	input  wire logic       bus_mode_sel_lo,   // Strap: fixed ack when high
	input  wire logic       cycle_start_n,     // Cycle start, active low
	input  wire logic       read_write_sel,    // High read, low write
	input  wire logic [0:7] host_addr_bus,     // Address, index 0 is MSB
	input  wire logic [0:7] host_data_upper_i, // Upper data lines in
	output logic      [0:7] host_data_upper_o, // Upper data lines out
	output logic            host_data_upper_oe,// Upper lines drive enable
	input  wire logic [0:7] host_data_lower_i, // Lower data lines in
	output logic      [0:7] host_data_lower_o, // Lower data lines out
	output logic            host_data_lower_oe,// Lower lines drive enable
	output logic            cycle_ack_n,       // Cycle acknowledge, active low
	output logic            irq_n,             // Interrupt, active low
	output logic            async_rx_pulse,    // Async packet received
	output logic            stream_rx_pulse,   // Stream packet received
	input  wire logic       host_defer_flag,   // Host busy input
	output logic            gp_clk_out,        // Divided clock output
	output logic      [7:0] core_addr,         // Core register address
	output logic     [15:0] core_wdata,        // Core write data
	output logic      [1:0] core_lanes,        // Core byte lanes
	output logic            core_wr,           // Core write strobe
	output logic            core_rd,           // Core read strobe
	input  wire logic[15:0] core_rdata,        // Core read data
	input  wire logic       core_done,         // Core access done pulse
	input  wire logic       irq_req,           // Core interrupt pending
	input  wire logic       async_rx_evt,      // Core async receive level
	input  wire logic       stream_rx_evt,     // Core stream receive level
	input  wire logic       queue_full,        // General receive queue full
	output logic            ack_busy           // Answer packets with busy code
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0]  mode_reg, mode_next;          // Captured strap code
	logic        mvld_reg, mvld_next;          // Strap captured
	hpp_state_t  st_reg, st_next;              // Cycle state
	logic [7:0]  addr_reg, addr_next;          // Latched address
	logic [15:0] wd_reg, wd_next;              // Latched write word
	logic [1:0]  lane_reg, lane_next;          // Latched lanes
	logic        rd_reg, rd_next, wr_reg, wr_next, rs_reg, rs_next; // Read cycle, strobes
	logic [7:0]  uo_reg, uo_next, lo_reg, lo_next;  // Upper and lower lines out
	logic        uoe_reg, uoe_next, loe_reg, loe_next; // Line enables
	logic        ack_reg, ack_next;            // Ack, active low
	logic [1:0]  fix_reg, fix_next;            // Fixed ack counter
	logic        irq_reg, irq_next, busy_reg, busy_next; // Interrupt low, busy answer
	logic [1:0]  div_reg, div_next;            // Divider count
	logic        gp_reg, gp_next;              // Divided clock
	logic        narrow, fixed;                // Narrow bus, fixed ack modes
	logic [7:0]  addr_v;                       // Address as a vector

	assign narrow = mode_reg[1];
	assign fixed  = mode_reg[0];
	assign addr_v = host_addr_bus;             // Index 0 lands on bit 7

	if (GP_DIV != 4 || FIX_ACK_CYC < 1 || FIX_ACK_CYC > 3) begin : g_bad // 2-bit counters
		$error("hpp_host_port: unsupported timing constants");
	end

	////////////////////////////////////////////////////////////////////
	// Strap capture, one cycle after reset release
	always_comb begin
		mode_next = mode_reg;
		mvld_next = 1'b1;
		if (!mvld_reg)
			mode_next = {bus_mode_sel_hi, bus_mode_sel_lo};
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode_reg <= MODE_RST;
			mvld_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			mvld_reg <= mvld_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus cycle machine
	always_comb begin
		st_next   = st_reg;
		rd_next   = rd_reg;
		addr_next = addr_reg;
		wd_next   = wd_reg;
		lane_next = lane_reg;
		wr_next   = 1'b0;
		rs_next   = 1'b0;
		uo_next   = uo_reg;
		lo_next   = lo_reg;
		uoe_next  = uoe_reg;
		loe_next  = loe_reg;
		ack_next  = ack_reg;
		fix_next  = fix_reg;
		case (st_reg)
			// Latch the cycle on start low
			ST_IDLE: begin
				if (mvld_reg && !cycle_start_n) begin
					rd_next   = read_write_sel;
					addr_next = addr_v;
					if (narrow) begin
						// Address LSB picks the byte
						addr_next = {addr_v[7:1], 1'b0};
						lane_next = addr_v[0] ? LANE_LOWER : LANE_UPPER;
						wd_next   = {host_data_lower_i, host_data_lower_i};
					end else begin
						lane_next = LANE_BOTH;
						wd_next   = {host_data_upper_i, host_data_lower_i};
					end
					st_next = ST_REQ;
				end
			end
			// One strobe to the core
			ST_REQ: begin
				wr_next = ~rd_reg;
				rs_next = rd_reg;
				st_next = ST_WAIT;
			end
			// Wait for the core, then drive read data and ack
			ST_WAIT: begin
				if (core_done) begin
					if (rd_reg) begin
						if (narrow) begin
							lo_next  = (lane_reg == LANE_LOWER) ? core_rdata[7:0]
							                                    : core_rdata[15:8];
							uoe_next = 1'b0;
						end else begin
							uo_next  = core_rdata[15:8];
							lo_next  = core_rdata[7:0];
							uoe_next = 1'b1;
						end
						loe_next = 1'b1;
					end
					ack_next = 1'b0;
					fix_next = 2'(FIX_ACK_CYC - 1);
					st_next  = ST_ACK;
				end
			end
			// Hold ack: to start release or for a fixed time
			ST_ACK: begin
				if (fixed) begin
					if (fix_reg == 2'h0) begin
						ack_next = 1'b1;
						uoe_next = 1'b0;
						loe_next = 1'b0;
						st_next  = ST_END;
					end else begin
						fix_next = fix_reg - 2'h1;
					end
				end else if (cycle_start_n) begin
					ack_next = 1'b1;
					uoe_next = 1'b0;
					loe_next = 1'b0;
					st_next  = ST_IDLE;
				end
			end
			// Fixed mode: wait until the host ends the cycle
			ST_END: begin
				if (cycle_start_n)
					st_next = ST_IDLE;
			end
			default: begin
				st_next  = ST_IDLE;
				ack_next = 1'b1;
				uoe_next = 1'b0;
				loe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg   <= ST_IDLE;
			{rd_reg, wr_reg, rs_reg} <= 3'h0;
			addr_reg <= 8'h00;
			wd_reg   <= 16'h0000;
			lane_reg <= LANE_BOTH;
			{uo_reg, lo_reg} <= 16'h0000;
			{uoe_reg, loe_reg} <= 2'h0;
			ack_reg  <= 1'b1;
			fix_reg  <= 2'h0;
		end else begin
			st_reg   <= st_next;
			{rd_reg, wr_reg, rs_reg} <= {rd_next, wr_next, rs_next};
			addr_reg <= addr_next;
			wd_reg   <= wd_next;
			lane_reg <= lane_next;
			{uo_reg, lo_reg} <= {uo_next, lo_next};
			{uoe_reg, loe_reg} <= {uoe_next, loe_next};
			ack_reg  <= ack_next;
			fix_reg  <= fix_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt, busy answer and clock divider
	always_comb begin
		irq_next  = ~irq_req;
		busy_next = host_defer_flag | queue_full;
		div_next  = div_reg + 2'h1;
		gp_next   = (div_next >= 2'(GP_HALF));
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			{irq_reg, busy_reg, gp_reg} <= 3'h4;
			div_reg  <= 2'h0;
		end else begin
			{irq_reg, busy_reg, gp_reg} <= {irq_next, busy_next, gp_next};
			div_reg  <= div_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive indicators
	hpp_pulse u_async_pulse (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.evt_level (async_rx_evt),
		.pulse     (async_rx_pulse)
	);

	hpp_pulse u_stream_pulse (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.evt_level (stream_rx_evt),
		.pulse     (stream_rx_pulse)
	);

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign {host_data_upper_o, host_data_lower_o} = {uo_reg, lo_reg};
	assign {host_data_upper_oe, host_data_lower_oe, cycle_ack_n} = {uoe_reg, loe_reg, ack_reg};
	assign {irq_n, ack_busy, gp_clk_out} = {irq_reg, busy_reg, gp_reg};
	assign {core_addr, core_wdata, core_lanes} = {addr_reg, wd_reg, lane_reg};
	assign {core_wr, core_rd} = {wr_reg, rs_reg};

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_narrow_upper_off: assert property (narrow |-> !host_data_upper_oe)
		else $error("upper lines driven in narrow mode");
	a_narrow_one_lane: assert property (core_wr && narrow |-> $onehot(core_lanes))
		else $error("narrow write not one lane");
	a_wide_both_lanes: assert property (core_wr && !narrow |-> core_lanes == LANE_BOTH)
		else $error("wide write not both lanes");
	a_hs_ack_hold: assert property (!cycle_ack_n && !fixed && !cycle_start_n
		|=> !cycle_ack_n)
		else $error("handshake ack released early");
	a_fix_ack_width: assert property ($fell(cycle_ack_n) && fixed
		|-> !cycle_ack_n ##1 !cycle_ack_n ##1 cycle_ack_n)
		else $error("fixed ack width wrong");
	a_ack_in_cycle: assert property ($fell(cycle_ack_n) |-> $past(core_done))
		else $error("ack without core completion");
	a_read_drive: assert property (host_data_lower_oe |-> rd_reg && !cycle_ack_n)
		else $error("data driven outside read ack");
	a_irq_follow: assert property (irq_req |=> !irq_n)
		else $error("interrupt not shown");
	a_async_once: assert property ($rose(async_rx_evt)
		|=> async_rx_pulse ##1 !async_rx_pulse)
		else $error("async pulse wrong");
	a_stream_once: assert property ($rose(stream_rx_evt)
		|=> stream_rx_pulse ##1 !stream_rx_pulse)
		else $error("stream pulse wrong");
	a_busy_answer: assert property (host_defer_flag |=> ack_busy)
		else $error("busy not answered");
	a_clk_quarter: assert property ($rose(gp_clk_out)
		|-> gp_clk_out ##1 gp_clk_out ##1 !gp_clk_out ##1 !gp_clk_out ##1 gp_clk_out)
		else $error("divided clock wrong");

	c_hs_read:    cover property (!fixed && rd_reg && $fell(cycle_ack_n));
	c_fix_write:  cover property (fixed && !rd_reg && $fell(cycle_ack_n));
	c_narrow_rd:  cover property (narrow && host_data_lower_oe);
	c_busy_defer: cover property (host_defer_flag && !queue_full ##1 ack_busy);
endmodule

// ===== logic/hpp_pkg.sv
package hpp_pkg;
	// Mode strap codes, written as {bus_mode_sel_hi, bus_mode_sel_lo}
	localparam logic [1:0] MODE_WIDE_HS    = 2'h0; // 16 lines, handshake ack
	localparam logic [1:0] MODE_WIDE_FIX   = 2'h1; // 16 lines, fixed ack
	localparam logic [1:0] MODE_NARROW_HS  = 2'h2; // Low byte lines, handshake ack
	localparam logic [1:0] MODE_NARROW_FIX = 2'h3; // Low byte lines, fixed ack
	localparam logic [1:0] MODE_RST        = 2'h0; // Mode before strap capture

	// Cycle counts
	localparam int FIX_ACK_CYC = 2;                // Fixed ack low time, cycles
	localparam int GP_DIV      = 4;                // Clock divide ratio
	localparam int GP_HALF     = GP_DIV / 2;       // Cycles per clock half

	// Byte lane codes
	localparam logic [1:0] LANE_BOTH  = 2'h3;      // Whole word
	localparam logic [1:0] LANE_UPPER = 2'h2;      // Upper byte only
	localparam logic [1:0] LANE_LOWER = 2'h1;      // Lower byte only

	// Bus cycle state machine, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,                           // Waiting for cycle start
		ST_REQ  = 5'h02,                           // Strobe to core
		ST_WAIT = 5'h04,                           // Waiting for core done
		ST_ACK  = 5'h08,                           // Acknowledge driven low
		ST_END  = 5'h10                            // Waiting for start release
	} hpp_state_t;
endpackage

// ===== logic/hpp_pulse.sv
`timescale 1ns/1ps
// One-cycle pulse on each rising edge of an event level
module hpp_pulse
	import hpp_pkg::*;
(
	input  wire logic mclk,      // Port clock
	input  wire logic rst_n,     // Synchronous reset, active low
	input  wire logic evt_level, // Event level from the core
	output logic      pulse      // One-cycle indicator
);
	logic evt_d_reg;             // Delayed event level
	logic evt_d_next;            // Its next value
	logic pulse_reg;             // Registered pulse
	logic pulse_next;            // Its next value

	////////////////////////////////////////////////////////////////////
	// Edge detect
	always_comb begin
		evt_d_next = evt_level;
		pulse_next = evt_level & ~evt_d_reg;
	end

	// Register stage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			evt_d_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			evt_d_reg <= evt_d_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse = pulse_reg;
endmodule

// ===== sim/hpp_mcu_model.sv
`timescale 1ns/1ps
// Microcontroller side of the host port
module hpp_mcu_model (
	input  wire logic       mclk,    // Port clock; pins move at most each 3rd cycle
	input  wire logic       ack_n,   // Cycle acknowledge from port
	input  wire logic [0:7] du_o,    // Upper lines from port
	input  wire logic [0:7] dl_o,    // Lower lines from port
	output logic            start_n, // Cycle start, active low
	output logic            rw,      // High read, low write
	output logic      [0:7] addr,    // Address lines
	output logic      [0:7] du_i,    // Upper lines to port
	output logic      [0:7] dl_i     // Lower lines to port
);
	// Idle bus at time zero
	initial begin
		start_n = 1'b1;
		rw = 1'b1;
		addr = 8'h00;
		{du_i, dl_i} = 16'h5aa5;
	end
	////////////////////////////////////////////////////////////////////////
	// One bus cycle; hold keeps start low that many cycles past the ack
	task automatic bus_cycle(input logic r, input logic [7:0] a, input logic [15:0] wd,
			input int hold, output logic [15:0] rd, output int w);
		int n;
		w = 0;
		@(negedge mclk);
		start_n = 1'b0;                          // Cycle opens with start low
		rw = r;                                  // High reads, low writes
		addr = a;                                // Index 0 carries the MSB
		{du_i, dl_i} = r ? ~{du_i, dl_i} : wd;   // Word split, MSB first
		for (n = 0; n < 40; n++) begin
			@(negedge mclk);
			if (ack_n === 1'b0) break;
		end
		rd = {du_o, dl_o};                       // Data valid with ack low
		w = (ack_n === 1'b0);
		repeat (hold) begin
			@(negedge mclk);
			w += (ack_n === 1'b0);
		end
		start_n = 1'b1;
		{du_i, dl_i} = ~{du_i, dl_i};            // Released lines show junk
		for (n = 0; n < 20; n++) begin
			@(negedge mclk);
			if (ack_n !== 1'b0) break;
			w++;
		end
		repeat (2) @(negedge mclk);
	endtask
endmodule

// ===== sim/test_hpp_host_port.sv
`timescale 1ns/1ps
// Self-checking bench for the host port
module test_hpp_host_port;
	import hpp_pkg::*;
	logic        mclk, rst_n, mode_hi, mode_lo;  // Clock, reset, straps
	logic        start_n, rw, ack_n, up_oe, lo_oe;  // Host handshake
	logic  [0:7] addr, du_i, du_o, dl_i, dl_o;   // Host lines
	logic        irq_req, irq_n, a_evt, s_evt, a_pls, s_pls;  // Events
	logic        defer, q_full, busy, gp_clk;    // Busy and clock
	logic  [7:0] c_addr;                         // Core side
	logic [15:0] c_wd;                           // Core write data
	logic  [1:0] c_ln;                           // Core lanes
	logic        c_wr, c_rd, c_done;             // Core strobes
	logic  [7:0] cap_addr;                       // Captured request
	logic [15:0] cap_wd;                         // Captured write data
	logic  [1:0] cap_ln;                         // Captured lanes
	logic        cap_wr, seen_up, seen_lo;       // Captured kind and enables
	int          dly, mismatches, num_checks;    // Core delay, counters

	hpp_host_port DUT (.mclk(mclk), .rst_n(rst_n), .bus_mode_sel_hi(mode_hi),
		.bus_mode_sel_lo(mode_lo), .cycle_start_n(start_n), .read_write_sel(rw),
		.host_addr_bus(addr), .host_data_upper_i(du_i), .host_data_upper_o(du_o),
		.host_data_upper_oe(up_oe), .host_data_lower_i(dl_i), .host_data_lower_o(dl_o),
		.host_data_lower_oe(lo_oe), .cycle_ack_n(ack_n), .irq_n(irq_n),
		.async_rx_pulse(a_pls), .stream_rx_pulse(s_pls), .host_defer_flag(defer),
		.gp_clk_out(gp_clk), .core_addr(c_addr), .core_wdata(c_wd), .core_lanes(c_ln),
		.core_wr(c_wr), .core_rd(c_rd), .core_rdata(16'hc3e1), .core_done(c_done),
		.irq_req(irq_req), .async_rx_evt(a_evt), .stream_rx_evt(s_evt),
		.queue_full(q_full), .ack_busy(busy));
	hpp_mcu_model MCU (.mclk(mclk), .ack_n(ack_n), .du_o(du_o), .dl_o(dl_o),
		.start_n(start_n), .rw(rw), .addr(addr), .du_i(du_i), .dl_i(dl_i));
	////////////////////////////////////////////////////////////////////////
	// Clock, 8 ns period
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Core responder: capture request, answer after dly cycles
	initial begin
		c_done = 1'b0;
		forever begin
			@(negedge mclk);
			if (c_rd === 1'b1 || c_wr === 1'b1) begin
				{cap_addr, cap_wd, cap_ln, cap_wr} = {c_addr, c_wd, c_ln, c_wr};
				repeat (dly) @(negedge mclk);
				c_done = 1'b1;
				@(negedge mclk);
				c_done = 1'b0;
			end
		end
	end
	// Drive enables seen while ack is low
	always @(negedge mclk) begin
		if (ack_n === 1'b0) begin
			seen_up <= up_oe;
			seen_lo <= lo_oe;
		end else if (rst_n === 1'b0) begin
			seen_up <= 1'b0;
			seen_lo <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Reset with straps, checking idle outputs during reset
	task automatic do_reset(input logic [1:0] m);
		rst_n = 1'b0;
		{mode_hi, mode_lo} = m;
		repeat (4) @(negedge mclk);
		chk({ack_n, irq_n, up_oe, lo_oe, busy, a_pls, gp_clk}, 7'h60);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
	endtask
	// Write then read in one strap mode
	task automatic t_mode(input logic [1:0] m);
		logic [15:0] rd;
		int w;
		do_reset(m);
		dly = m;
		MCU.bus_cycle(1'b0, 8'h5b, 16'ha53c, 3, rd, w);
		chk(cap_wr, 1'b1);
		chk(cap_addr, m[1] ? 8'h5a : 8'h5b);
		chk(cap_ln, m[1] ? LANE_LOWER : LANE_BOTH);
		chk(cap_wd, m[1] ? 16'h3c3c : 16'ha53c);
		chk(16'(w), m[0] ? 16'(FIX_ACK_CYC) : 16'h4);
		chk({seen_up, seen_lo}, 2'h0);
		MCU.bus_cycle(1'b1, 8'h24, 16'h0000, 0, rd, w);
		chk(cap_wr, 1'b0);
		chk(16'(w), m[0] ? 16'(FIX_ACK_CYC) : 16'h1);
		chk(cap_ln, m[1] ? LANE_UPPER : LANE_BOTH);
		chk(m[1] ? {8'h00, rd[7:0]} : rd, m[1] ? 16'h00c3 : 16'hc3e1);
		chk({seen_up, seen_lo}, {!m[1], 1'b1});
	endtask
	// Interrupt, receive pulses and busy answer
	task automatic t_events();
		int na;
		int ns;
		na = 0;
		ns = 0;
		irq_req = 1'b1;
		repeat (2) @(negedge mclk);
		chk(irq_n, 1'b0);
		irq_req = 1'b0;
		a_evt = 1'b1;
		s_evt = 1'b1;
		repeat (8) begin
			@(negedge mclk);
			na += a_pls;
			ns += s_pls;
		end
		chk(irq_n, 1'b1);
		chk(16'(na), 16'h1);
		chk(16'(ns), 16'h1);
		{a_evt, s_evt, defer} = 3'b001;
		repeat (2) @(negedge mclk);
		chk(busy, 1'b1);
		{defer, q_full} = 2'b01;
		repeat (2) @(negedge mclk);
		chk(busy, 1'b1);
		q_full = 1'b0;
		repeat (2) @(negedge mclk);
		chk(busy, 1'b0);
	endtask
	// Divided clock: four rises and half high over sixteen cycles
	task automatic t_gpclk();
		int hi;
		int rises;
		logic prev;
		hi = 0;
		rises = 0;
		prev = gp_clk;
		repeat (16) begin
			@(negedge mclk);
			hi += gp_clk;
			rises += (gp_clk && !prev);
			prev = gp_clk;
		end
		chk(16'(hi), 16'h8);
		chk(16'(rises), 16'(16 / GP_DIV));
	endtask
	// Verdict
	task automatic results();
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{irq_req, a_evt, s_evt} = 3'h0;
		{defer, q_full} = 2'h0;
		{dly, mismatches, num_checks} = 0;
		for (int m = 0; m < 4; m++) t_mode(2'(m));
		t_events();
		t_gpclk();
		results();
	end
	// Watchdog
	initial begin
		#(8 * 2000);
		mismatches++;
		results();
	end
endmodule
